// ---- verif/pot_link_checker.sv ----
// assertions on the serial link between the pot controller and the pot device
// assumes the controller runs sck with four system clocks per half period
`timescale 1ns/1ps
`default_nettype none
module pot_link_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence frame_open;
    $fell(cs_n);
  endsequence
  sequence frame_close;
    $rose(cs_n);
  endsequence
  sequence high_half;
    sck [*3];
  endsequence
  sequence low_half;
    !sck [*3];
  endsequence

  idle_clock_a: assert property (cs_n |-> !sck)
    else $error("sck moved outside a frame");
  high_phase_a: assert property ($rose(sck) |=> high_half)
    else $error("sck high phase too short");
  low_phase_a: assert property ($fell(sck) |=> low_half)
    else $error("sck low phase too short");
  si_steady_a: assert property (!cs_n && $changed(si) |-> !sck)
    else $error("si changed while sck high");
  so_steady_a: assert property (so_oe && $changed(so) |-> !sck)
    else $error("so changed while sck high");
  frame_gap_a: assert property (frame_close |=> cs_n [*3])
    else $error("select gap too short");
  oe_quiet_a: assert property (frame_open |=> !so_oe [*8])
    else $error("device drove so during header");
  oe_release_a: assert property (frame_close |-> ##[1:6] !so_oe)
    else $error("so not released after frame");
  oe_in_frame_a: assert property ($rose(so_oe) |-> !cs_n)
    else $error("so driven while deselected");
  line_idle_a: assert property (cs_n [*5] |-> !so_oe && so_line)
    else $error("released so line not high");
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// bench: ahb-lite master drives the controller, which frames commands to the pot device
// assumes one clock for both ends; cut resets only the host to break a frame
`timescale 1ns/1ps
`default_nettype none
`include "pot_params.svh"
module tb_top;
  localparam logic [1:0] DEV_A = 2'h2;
  logic        i_clk, rst, cut, rst_h, hsel, hwrite, hready, hresp, irq, write_in_progress_flag, rd_ph;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [23:0] wiper;
  logic [5:0]  wexp [4];
  logic [5:0]  sexp [16];
  logic [31:0] expq [$];
  int          num_errors, total_checks;

  pot_spi_if link_if ();
  assign rst_h = rst | cut;
  pot_spi_controller #(.HALF_CYCLES(4)) pot_spi_controller_inst (
    .i_clk(i_clk), .i_rst(rst_h), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp), .o_irq(irq),
    .link(link_if.host));
  // short nv timer so the busy window spans one following frame
  quad_pot_spi_command_decoder #(.NV_WRITE_CYCLES(400)) quad_pot_spi_command_decoder_inst (
    .i_clk(i_clk), .i_rst(rst), .i_strap_addr(DEV_A), .link(link_if.dev),
    .o_wiper(wiper), .o_write_in_progress(write_in_progress_flag));
  pot_link_checker pot_link_checker_inst (
    .i_clk(i_clk), .i_rst(rst_h), .cs_n(link_if.cs_n), .sck(link_if.sck), .si(link_if.si),
    .so(link_if.so), .so_oe(link_if.so_oe), .so_line(link_if.so_line));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // read results pair with the oldest expectation noted by the driver
  always @(posedge i_clk)
  begin
    if (rd_ph && hready === 1'b1 && expq.size() > 0)
    begin
      chk(hrdata, expq.pop_front(), "read");
      chk({31'h0, hresp}, 32'h0, "resp");
    end
    rd_ph <= hsel & htrans[1] & ~hwrite & hready;
  end

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  // w selects the write-in-progress flag, else the interrupt line
  task automatic wait_lvl(input logic w, input logic v);
    int n;
    n = 0;
    while ((w ? write_in_progress_flag : irq) !== v && n < 5000)
    begin
      @(posedge i_clk);
      n++;
    end
    chk({31'h0, w ? write_in_progress_flag : irq}, {31'h0, v}, "wait");
  endtask

  task automatic run(input logic [3:0] op, input logic [3:0] sel, input logic [8:0] d,
                     input logic [1:0] a = DEV_A);
    ahb(1'b1, `REG_DATA, {23'h0, d});
    ahb(1'b1, `REG_CMD, {22'h0, a, op, sel});
    wait_lvl(1'b0, 1'b1);
    ahb(1'b1, `REG_IRQ_STATUS, 32'h3);
  endtask

  task automatic look(input logic iq, input logic wp);
    repeat (2) @(negedge i_clk);
    chk({8'h0, wiper}, {8'h0, wexp[3], wexp[2], wexp[1], wexp[0]}, "wiper");
    chk({30'h0, irq, write_in_progress_flag}, {30'h0, iq, wp}, "irq wip");
    @(posedge i_clk);
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial
  begin
    #2000000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    {rst, cut, hsel, hwrite, htrans, haddr, hwdata} = {4'b1000, 66'h0};
    seed = 32'h1244770F;
    num_errors = 0;
    total_checks = 0;
    foreach (wexp[i]) wexp[i] = 6'h00;
    foreach (sexp[i]) sexp[i] = 6'h00;
    repeat (5) @(posedge i_clk);
    rst <= 1'b0;
    @(posedge i_clk);
    look(1'b0, 1'b0);
    ahb(1'b1, `REG_IRQ_MASK, 32'h1);
    for (int p = 0; p < 4; p++)
    begin
      seed = lfsr(seed);
      wexp[p] = seed[5:0];
      run(`OP_WR_WIPER, {2'h0, p[1:0]}, {3'h0, wexp[p]});
    end
    look(1'b0, 1'b0);
    run(`OP_WR_WIPER, 4'h0, {3'h0, ~wexp[0]}, ~DEV_A);
    look(1'b0, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      run(`OP_RD_WIPER, {2'h0, p[1:0]}, 9'h0);
      rd(`REG_RX, {26'h0, wexp[p]});
    end
    $display("test end: wiper access");
    seed = lfsr(seed);
    sexp[11] = seed[5:0];
    run(`OP_WR_SET, 4'hB, {3'h0, sexp[11]});
    look(1'b0, 1'b1);
    run(`OP_STATUS, `STATUS_SEL, 9'h0);
    rd(`REG_RX, 32'h1);
    wait_lvl(1'b1, 1'b0);
    run(`OP_STATUS, `STATUS_SEL, 9'h0);
    rd(`REG_RX, 32'h0);
    run(`OP_RD_SET, 4'hB, 9'h0);
    rd(`REG_RX, {26'h0, sexp[11]});
    run(`OP_WIPER_TO_SET, 4'h6, 9'h0);
    sexp[6] = wexp[2];
    look(1'b0, 1'b1);
    wait_lvl(1'b1, 1'b0);
    wexp[2] = ~wexp[2];
    run(`OP_WR_WIPER, 4'h2, {3'h0, wexp[2]});
    run(`OP_SET_TO_WIPER, 4'h6, 9'h0);
    wexp[2] = sexp[6];
    look(1'b0, 1'b0);
    $display("test end: stored settings");
    run(`OP_GLB_WIP_TO_SET, 4'hC, 9'h0);
    for (int p = 0; p < 4; p++) sexp[12 + p] = wexp[p];
    look(1'b0, 1'b1);
    wait_lvl(1'b1, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      seed = lfsr(seed);
      wexp[p] = seed[5:0];
      run(`OP_WR_WIPER, {2'h0, p[1:0]}, {3'h0, wexp[p]});
    end
    run(`OP_GLB_SET_TO_WIP, 4'hC, 9'h0);
    for (int p = 0; p < 4; p++) wexp[p] = sexp[12 + p];
    look(1'b0, 1'b0);
    run(`OP_RD_SET, 4'hD, 9'h0);
    rd(`REG_RX, {26'h0, sexp[13]});
    $display("test end: global transfers");
    wexp[1] = 6'h3D;
    run(`OP_WR_WIPER, 4'h1, {3'h0, wexp[1]});
    run(`OP_STEP, 4'hD, 9'h104);
    wexp[1] = `WIPER_MAX;
    look(1'b0, 1'b0);
    run(`OP_STEP, 4'h1, 9'h005);
    wexp[1] = 6'h3A;
    look(1'b0, 1'b0);
    run(`OP_STEP, 4'h1, 9'h040);
    wexp[1] = 6'h00;
    look(1'b0, 1'b0);
    $display("test end: stepping");
    ahb(1'b1, `REG_DATA, {26'h0, ~wexp[3]});
    ahb(1'b1, `REG_CMD, {22'h0, DEV_A, `OP_WR_WIPER, 4'h3});
    // a host reset mid frame is the only way to cut the select short
    repeat (150) @(posedge i_clk);
    cut <= 1'b1;
    @(posedge i_clk);
    cut <= 1'b0;
    repeat (8) @(posedge i_clk);
    look(1'b0, 1'b0);
    ahb(1'b1, `REG_IRQ_MASK, 32'h1);
    $display("test end: cut frame");
    ahb(1'b1, `REG_CMD, {22'h0, DEV_A, `OP_RD_WIPER, 4'h0});
    ahb(1'b1, `REG_CMD, {22'h0, DEV_A, `OP_RD_WIPER, 4'h1});
    rd(`REG_IRQ_STATUS, 32'h2);
    rd(`REG_STATUS, 32'h1);
    // the refused second command must not replace the running one
    rd(`REG_CMD, {22'h0, DEV_A, `OP_RD_WIPER, 4'h0});
    look(1'b0, 1'b0);
    ahb(1'b1, `REG_IRQ_MASK, 32'h3);
    look(1'b1, 1'b0);
    ahb(1'b1, `REG_IRQ_STATUS, 32'h2);
    look(1'b0, 1'b0);
    wait_lvl(1'b0, 1'b1);
    ahb(1'b1, `REG_IRQ_STATUS, 32'h3);
    rd(`REG_STATUS, 32'h0);
    rd(`REG_RX, {26'h0, wexp[0]});
    rd(8'h18, 32'h0);
    rd(`REG_IRQ_MASK, 32'h3);
    look(1'b0, 1'b0);
    $display("test end: registers and interrupt");
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- verilog/pot_params.svh ----
// constants shared by both ends of the quad pot serial link
// assumes a 20 MHz system clock on both ends
`ifndef POT_PARAMS_SVH
`define POT_PARAMS_SVH

`define CLK_PERIOD_NS      50
`define SCK_PERIOD_NS      400
`define NV_WRITE_NS        5000000

`define TYPE_ID            4'h5
`define OP_RD_WIPER        4'h9
`define OP_WR_WIPER        4'hA
`define OP_RD_SET          4'hB
`define OP_WR_SET          4'hC
`define OP_SET_TO_WIPER    4'hD
`define OP_WIPER_TO_SET    4'hE
`define OP_GLB_SET_TO_WIP  4'h1
`define OP_GLB_WIP_TO_SET  4'h8
`define OP_STEP            4'h2
`define OP_STATUS          4'h5
`define STATUS_SEL         4'h1
`define WIPER_MAX          6'h3F
`define WIPER_RESET        6'h00

`define REG_CMD            8'h00
`define REG_DATA           8'h04
`define REG_RX             8'h08
`define REG_STATUS         8'h0C
`define REG_IRQ_STATUS     8'h10
`define REG_IRQ_MASK       8'h14
`define CMD_OP_LSB         4
`define CMD_ADDR_LSB       8
`define DATA_DIR_BIT       8
`define IRQ_DONE_BIT       0
`define IRQ_REFUSED_BIT    1

`endif

// ---- verilog/pot_pkg.sv ----
// types for both ends of the quad pot serial link
// assumes pot_params.svh for the numeric constants
`default_nettype none
package pot_pkg;

  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_RECV = 5'b00010,
    D_READ = 5'b00100,
    D_STEP = 5'b01000,
    D_WAIT = 5'b10000
  } dev_st_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LOW  = 5'b00010,
    H_HIGH = 5'b00100,
    H_TAIL = 5'b01000,
    H_GAP  = 5'b10000
  } host_st_t;

  typedef struct packed {
    dev_st_t          st;
    logic             cs_m, cs_s, cs_p;
    logic             sck_m, sck_s, sck_p;
    logic             si_m, si_s;
    logic [1:0]       strap_m, strap_s;
    logic [4:0]       nbits;
    logic [7:0]       shf;
    logic [7:0]       cmd;
    logic [7:0]       out;
    logic             so;
    logic             so_oe;
    logic             done;
    logic [3:0][5:0]  wiper;
    logic [15:0][5:0] store;
    logic [31:0]      wip_cnt;
    logic             write_in_progress_flag;
  } dev_state_t;

  typedef struct packed {
    host_st_t    st;
    logic [7:0]  div;
    logic [8:0]  cnt;
    logic [8:0]  nbits;
    logic [23:0] tx;
    logic [7:0]  rx;
    logic        cs_n, sck, si, dir;
    logic        so_m, so_s;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [9:0]  cmd;
    logic [8:0]  data;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
  } host_state_t;

endpackage
`default_nettype wire

// ---- verilog/pot_spi_controller.sv ----
// host end: ahb-lite register slave that builds and clocks pot frames
// assumes the device answers on the link's serial output line
`timescale 1ns/1ps
`default_nettype none
`include "pot_params.svh"
module pot_spi_controller #(
  parameter int HALF_CYCLES = `SCK_PERIOD_NS / 2 / `CLK_PERIOD_NS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic [31:0]      o_hrdata,
  output logic             o_hresp,
  output logic             o_irq,
  pot_spi_if.host          link
);

  pot_pkg::host_state_t s_q;
  pot_pkg::host_state_t s_d;

  function automatic logic [8:0] frame_bits(input logic [3:0] op, input logic [7:0] steps);
    unique case (op)
      `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_SET, `OP_WR_SET, `OP_STATUS:
        frame_bits = 9'd24;
      `OP_STEP:
        frame_bits = 9'd16 + {1'b0, steps};
      default:
        frame_bits = 9'd16;
    endcase
  endfunction

  logic       addr_ph;
  logic       busy;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [7:0] half;

  always_comb
  begin
    s_d = s_q;
    s_d.so_m = link.so_line;
    s_d.so_s = s_q.so_m;
    addr_ph = i_hsel & i_htrans[1] & i_hready;
    busy    = (s_q.st != pot_pkg::H_IDLE);
    irq_set = 2'b00;
    irq_clr = 2'b00;
    half    = 8'(HALF_CYCLES - 1);

    s_d.wr_pend = addr_ph & i_hwrite;
    if (addr_ph)
      s_d.wr_addr = i_haddr[7:0];
    if (addr_ph & ~i_hwrite)
    begin
      unique case (i_haddr[7:0])
        `REG_CMD:        s_d.rdata = {22'h0, s_q.cmd};
        `REG_DATA:       s_d.rdata = {23'h0, s_q.data};
        `REG_RX:         s_d.rdata = {24'h0, s_q.rx};
        `REG_STATUS:     s_d.rdata = {31'h0, busy};
        `REG_IRQ_STATUS: s_d.rdata = {30'h0, s_q.irq_st};
        `REG_IRQ_MASK:   s_d.rdata = {30'h0, s_q.irq_mask};
        default:         s_d.rdata = 32'h0;
      endcase
    end

    if (s_q.div != 8'h00)
      s_d.div = s_q.div - 8'h01;

    unique case (s_q.st)
      pot_pkg::H_IDLE:
      begin
      end
      pot_pkg::H_LOW:
      begin
        if (s_q.div == 8'h00)
        begin
          s_d.sck = 1'b1;
          s_d.div = half;
          s_d.st  = pot_pkg::H_HIGH;
        end
      end
      pot_pkg::H_HIGH:
      begin
        if (s_q.div == 8'h00)
        begin
          // sampled late in the high phase to cover both synchronisers
          s_d.rx  = {s_q.rx[6:0], s_q.so_s};
          s_d.sck = 1'b0;
          s_d.tx  = {s_q.tx[22:0], s_q.dir};
          s_d.si  = s_q.tx[22];
          s_d.cnt = s_q.cnt + 9'd1;
          s_d.div = half;
          s_d.st  = (s_q.cnt + 9'd1 == s_q.nbits) ? pot_pkg::H_TAIL : pot_pkg::H_LOW;
        end
      end
      pot_pkg::H_TAIL:
      begin
        if (s_q.div == 8'h00)
        begin
          s_d.cs_n = 1'b1;
          s_d.div  = half;
          s_d.st   = pot_pkg::H_GAP;
        end
      end
      pot_pkg::H_GAP:
      begin
        if (s_q.div == 8'h00)
        begin
          s_d.st = pot_pkg::H_IDLE;
          irq_set[`IRQ_DONE_BIT] = 1'b1;
        end
      end
    endcase

    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_addr)
        `REG_CMD:
        begin
          if (busy)
            irq_set[`IRQ_REFUSED_BIT] = 1'b1;
          else
          begin
            s_d.cmd   = i_hwdata[9:0];
            s_d.nbits = frame_bits(i_hwdata[7:4], s_q.data[7:0]);
            s_d.dir   = s_q.data[`DATA_DIR_BIT];
            s_d.tx    = {`TYPE_ID, 2'b00, i_hwdata[9:8], i_hwdata[7:0],
                         (i_hwdata[7:4] == `OP_STEP) ? {8{s_q.data[`DATA_DIR_BIT]}}
                                                     : s_q.data[7:0]};
            s_d.si    = 1'b0;
            s_d.cs_n  = 1'b0;
            s_d.cnt   = 9'd0;
            s_d.div   = half;
            s_d.st    = pot_pkg::H_LOW;
          end
        end
        `REG_DATA:      s_d.data     = i_hwdata[8:0];
        `REG_IRQ_STATUS: irq_clr     = i_hwdata[1:0];
        `REG_IRQ_MASK:  s_d.irq_mask = i_hwdata[1:0];
        default:
        begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_set;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q      <= '0;
      s_q.st   <= pot_pkg::H_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.so_m <= 1'b1;
      s_q.so_s <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = s_q.rdata;
  assign o_irq       = |(s_q.irq_st & s_q.irq_mask);
  assign link.cs_n   = s_q.cs_n;
  assign link.sck    = s_q.sck;
  assign link.si     = s_q.si;

endmodule
`default_nettype wire

// ---- verilog/pot_spi_if.sv ----
// serial link between the pot controller and the quad pot device
// the serial output line idles high when the device does not drive it
`timescale 1ns/1ps
`default_nettype none
interface pot_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  assign so_line = so_oe ? so : 1'b1;

  modport dev  (input cs_n, sck, si, output so, so_oe);
  modport host (output cs_n, sck, si, input so_line);
endinterface
`default_nettype wire

// ---- verilog/quad_pot_spi_command_decoder.sv ----
// device end: decodes serial frames and holds wiper and stored settings
// assumes link pins asynchronous to i_clk; sck well below i_clk / 6
`timescale 1ns/1ps
`default_nettype none
`include "pot_params.svh"

module quad_pot_spi_command_decoder #(
  parameter int NV_WRITE_CYCLES = `NV_WRITE_NS / `CLK_PERIOD_NS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [1:0]  i_strap_addr,
  pot_spi_if.dev           link,
  output logic [23:0]      o_wiper,
  output logic             o_write_in_progress
);

  pot_pkg::dev_state_t s_q;
  pot_pkg::dev_state_t s_d;

  function automatic logic [5:0] step_pos(input logic [5:0] p, input logic up);
    if (up)
      step_pos = (p == `WIPER_MAX) ? p : p + 6'h01;
    else
      step_pos = (p == 6'h00) ? p : p - 6'h01;
  endfunction

  logic [7:0] sh;
  logic       rise;
  logic       fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       nv_ok;

  always_comb
  begin
    s_d = s_q;
    s_d.cs_m    = link.cs_n;
    s_d.cs_s    = s_q.cs_m;
    s_d.cs_p    = s_q.cs_s;
    s_d.sck_m   = link.sck;
    s_d.sck_s   = s_q.sck_m;
    s_d.sck_p   = s_q.sck_s;
    s_d.si_m    = link.si;
    s_d.si_s    = s_q.si_m;
    s_d.strap_m = i_strap_addr;
    s_d.strap_s = s_q.strap_m;
    rise    = s_q.sck_s & ~s_q.sck_p;
    fall    = ~s_q.sck_s & s_q.sck_p;
    cs_fall = ~s_q.cs_s & s_q.cs_p;
    cs_rise = s_q.cs_s & ~s_q.cs_p;
    sh      = {s_q.shf[6:0], s_q.si_s};
    // a second nonvolatile write is refused while one is running
    nv_ok   = ~s_q.write_in_progress_flag;

    if (s_q.wip_cnt != 32'h0)
      s_d.wip_cnt = s_q.wip_cnt - 32'h1;
    s_d.write_in_progress_flag = (s_d.wip_cnt != 32'h0);

    unique case (s_q.st)
      pot_pkg::D_IDLE:
      begin
        s_d.so_oe = 1'b0;
      end
      pot_pkg::D_RECV:
      begin
        if (rise)
        begin
          s_d.shf   = sh;
          s_d.nbits = s_q.nbits + 5'd1;
          if (s_q.nbits == 5'd7)
          begin
            if (sh[7:4] != `TYPE_ID || sh[3:2] != 2'b00 || sh[1:0] != s_q.strap_s)
              s_d.st = pot_pkg::D_WAIT;
          end
          else if (s_q.nbits == 5'd15)
          begin
            s_d.cmd = sh;
            unique case (sh[7:4])
              `OP_RD_WIPER:
              begin
                s_d.out = {2'b00, s_q.wiper[sh[1:0]]};
                s_d.st  = pot_pkg::D_READ;
              end
              `OP_RD_SET:
              begin
                s_d.out = {2'b00, s_q.store[sh[3:0]]};
                s_d.st  = pot_pkg::D_READ;
              end
              `OP_STATUS:
              begin
                s_d.out = {7'h00, s_q.write_in_progress_flag};
                s_d.st  = (sh[3:0] == `STATUS_SEL) ? pot_pkg::D_READ : pot_pkg::D_WAIT;
              end
              `OP_STEP:
              begin
                s_d.st = pot_pkg::D_STEP;
              end
              `OP_WR_WIPER, `OP_WR_SET:
              begin
                s_d.st = pot_pkg::D_RECV;
              end
              `OP_SET_TO_WIPER, `OP_WIPER_TO_SET, `OP_GLB_SET_TO_WIP, `OP_GLB_WIP_TO_SET:
              begin
                s_d.done = 1'b1;
                s_d.st   = pot_pkg::D_WAIT;
              end
              default:
              begin
                s_d.st = pot_pkg::D_WAIT;
              end
            endcase
          end
          else if (s_q.nbits == 5'd23)
          begin
            s_d.done = 1'b1;
            s_d.st   = pot_pkg::D_WAIT;
          end
        end
      end
      pot_pkg::D_READ:
      begin
        if (fall)
        begin
          s_d.so    = s_q.out[7];
          s_d.so_oe = 1'b1;
          s_d.out   = {s_q.out[6:0], 1'b0};
        end
      end
      pot_pkg::D_STEP:
      begin
        if (rise)
          s_d.wiper[s_q.cmd[1:0]] = step_pos(s_q.wiper[s_q.cmd[1:0]], s_q.si_s);
      end
      pot_pkg::D_WAIT:
      begin
        s_d.so_oe = 1'b0;
      end
    endcase

    // the frame takes effect when chip select ends it, except a step, which moves the wiper on each sck rise
    if (cs_rise)
    begin
      if (s_q.done)
      begin
        unique case (s_q.cmd[7:4])
          `OP_WR_WIPER:
            s_d.wiper[s_q.cmd[1:0]] = s_q.shf[5:0];
          `OP_WR_SET:
            if (nv_ok)
            begin
              s_d.store[s_q.cmd[3:0]] = s_q.shf[5:0];
              s_d.wip_cnt = 32'(NV_WRITE_CYCLES);
            end
          `OP_SET_TO_WIPER:
            s_d.wiper[s_q.cmd[1:0]] = s_q.store[s_q.cmd[3:0]];
          `OP_WIPER_TO_SET:
            if (nv_ok)
            begin
              s_d.store[s_q.cmd[3:0]] = s_q.wiper[s_q.cmd[1:0]];
              s_d.wip_cnt = 32'(NV_WRITE_CYCLES);
            end
          `OP_GLB_SET_TO_WIP:
            for (int i = 0; i < 4; i++)
              s_d.wiper[i] = s_q.store[{s_q.cmd[3:2], 2'(i)}];
          `OP_GLB_WIP_TO_SET:
            if (nv_ok)
            begin
              for (int i = 0; i < 4; i++)
                s_d.store[{s_q.cmd[3:2], 2'(i)}] = s_q.wiper[i];
              s_d.wip_cnt = 32'(NV_WRITE_CYCLES);
            end
          default:
          begin
          end
        endcase
        s_d.write_in_progress_flag = (s_d.wip_cnt != 32'h0);
      end
      s_d.st    = pot_pkg::D_IDLE;
      s_d.done  = 1'b0;
      s_d.so_oe = 1'b0;
    end
    else if (cs_fall)
    begin
      s_d.st    = pot_pkg::D_RECV;
      s_d.nbits = 5'd0;
      s_d.done  = 1'b0;
      s_d.so_oe = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q         <= '0;
      s_q.st      <= pot_pkg::D_IDLE;
      s_q.cs_m    <= 1'b1;
      s_q.cs_s    <= 1'b1;
      s_q.cs_p    <= 1'b1;
      s_q.so      <= 1'b1;
      s_q.wiper   <= {4{`WIPER_RESET}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.so             = s_q.so;
  assign link.so_oe          = s_q.so_oe;
  assign o_wiper             = s_q.wiper;
  assign o_write_in_progress = s_q.write_in_progress_flag;

endmodule
`default_nettype wire
